// ===== inc/lcdsd_pkg.sv
// Constants and types shared by the LCD serial command decoder
`default_nettype none
package lcdsd_pkg;
  localparam int LCDSD_FIFO_DEPTH = 32;
  localparam int LCDSD_FIFO_WIDTH = 9;
  localparam int LCDSD_PAGES = 9;
  localparam int LCDSD_COLS = 132;
  localparam logic [7:0] LCDSD_COL_LAST = 8'h83;
  localparam logic [2:0] LCDSD_BIT_LAST = 3'h7;
  // Opcodes and opcode ranges
  localparam logic [7:0] OP_DISP_OFF = 8'hAE;
  localparam logic [7:0] OP_DISP_ON = 8'hAF;
  localparam logic [7:0] OP_START_LO = 8'h40;
  localparam logic [7:0] OP_START_HI = 8'h7F;
  localparam logic [7:0] OP_PAGE_LO = 8'hB0;
  localparam logic [7:0] OP_PAGE_HI = 8'hB8;
  localparam logic [7:0] OP_COLH_LO = 8'h10;
  localparam logic [7:0] OP_COLH_HI = 8'h1F;
  localparam logic [7:0] OP_COLL_LO = 8'h00;
  localparam logic [7:0] OP_COLL_HI = 8'h0F;
  localparam logic [7:0] OP_ADC_NORM = 8'hA0;
  localparam logic [7:0] OP_ADC_REV = 8'hA1;
  localparam logic [7:0] OP_BIAS_LO = 8'hA2;
  localparam logic [7:0] OP_BIAS_HI = 8'hA3;
  localparam logic [7:0] OP_ALLON_LO = 8'hA4;
  localparam logic [7:0] OP_ALLON_HI = 8'hA5;
  localparam logic [7:0] OP_INV_LO = 8'hA6;
  localparam logic [7:0] OP_INV_HI = 8'hA7;
  localparam logic [7:0] OP_RMW = 8'hE0;
  localparam logic [7:0] OP_RMW_END = 8'hEE;
  localparam logic [7:0] OP_SOFT_RESET = 8'hE2;
  localparam logic [7:0] OP_NOP = 8'hE3;
  localparam logic [7:0] OP_OSC_LO = 8'hE4;
  localparam logic [7:0] OP_OSC_HI = 8'hE5;
  localparam logic [7:0] OP_DCDC = 8'hE6;
  localparam logic [7:0] OP_COMDIR_LO = 8'hC0;
  localparam logic [7:0] OP_COMDIR_HI = 8'hCF;
  localparam logic [7:0] OP_POWER_LO = 8'h28;
  localparam logic [7:0] OP_POWER_HI = 8'h2F;
  localparam logic [7:0] OP_RATIO_LO = 8'h20;
  localparam logic [7:0] OP_RATIO_HI = 8'h27;
  localparam logic [7:0] OP_VOLUME = 8'h81;
  localparam logic [7:0] OP_IND_LO = 8'hAC;
  localparam logic [7:0] OP_IND_HI = 8'hAD;
  localparam logic [7:0] OP_PART_LO = 8'h82;
  localparam logic [7:0] OP_PART_HI = 8'h83;
  localparam logic [7:0] OP_PDUTY_LO = 8'h30;
  localparam logic [7:0] OP_PDUTY_HI = 8'h37;
  localparam logic [7:0] OP_PBIAS_LO = 8'h38;
  localparam logic [7:0] OP_PBIAS_HI = 8'h3F;
  localparam logic [7:0] OP_PSTART = 8'hD3;
  localparam logic [7:0] OP_NLINE_ON = 8'h85;
  localparam logic [7:0] OP_NLINE_OFF = 8'h84;
  // Values after reset
  localparam logic [5:0] RST_START_LINE = 6'h00;
  localparam logic [3:0] RST_PAGE = 4'h0;
  localparam logic [7:0] RST_COLUMN = 8'h00;
  localparam logic [5:0] RST_VOLUME = 6'h20;
  localparam logic [2:0] RST_RATIO = 3'h0;
  localparam logic [2:0] RST_POWER = 3'h0;
  localparam logic [3:0] RST_DCDC = 4'h0;
  localparam logic [4:0] RST_NLINE = 5'h00;
  // Second-byte expectation after a two-byte command
  typedef enum logic [2:0] {
    LCDSD_EXP_CMD,
    LCDSD_EXP_VOLUME,
    LCDSD_EXP_INDICATOR,
    LCDSD_EXP_PSTART,
    LCDSD_EXP_NLINE,
    LCDSD_EXP_DCDC
  } lcdsd_expect_t;
endpackage
`default_nettype wire

// ===== logic/lcdsd_decoder.sv
// Serial receiver, byte FIFO and command decoder with display RAM
//
// Summary of operation
// R1: Select line high marks display data; low marks a command byte.
// R2: Init pin held low returns every setting to its initial value.
// R3: Serial bits are accepted only while chip select is low.
// R4: 0xAE/0xAF switch the panel off/on by bit 0.
// R5: 0x40..0x7F load the low six bits as display start line.
// R6: 0xB0..0xB8 load the low four bits as page address.
// R7: 0001xxxx loads column upper nibble, 0000xxxx loads lower nibble.
// R8: Status byte carries flags in upper nibble, zeros in lower nibble.
// R9: Data byte is written to display RAM at current page and column.
// R10: Data read returns RAM at page and column where a read path exists.
// R11: 0xA0/0xA1 select normal or mirrored column driver order.
// R12: 0xA6/0xA7 select normal or inverted pixels, 1 inverted.
// R13: 0xA4/0xA5 select normal display or all pixels on.
// R14: 0xA2/0xA3 set drive bias ratio by bit 0.
// R15: 0xE0 enters read-modify-write, 0xEE leaves and restores column.
// R16: 0xC0..0xCF set row scan direction from bit 3.
// R17: 0x28..0x2F load three-bit power circuit mode.
// R18: 0x20..0x27 load three-bit regulator resistor ratio.
// R19: After 0x81 the next command byte is the electronic volume.
// R20: 0xAC/0xAD switch the indicator; next byte sets flashing mode.
// R21: Partial display mode, duty, bias, and 0xD3 plus value start line.
// R22: 0x85 plus count enables N-line inversion; 0x84 turns it off.
// R23: Soft reset reinitialises pointers and mode registers, keeps RAM.
// R24: Display RAM cannot be read over the serial link.
// R25: Bytes are eight bits, MSB first, sampled on rising serial clock.
// R26: Test and undefined codes are ignored; 0xE3 does nothing.
// R27: 0xE4/0xE5 select oscillator frequency by bit 0.
`timescale 1ns/1ps
`default_nettype none

module lcdsd_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 32
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic FLUSH,
  input wire logic [WIDTH-1:0] IN_DATA,
  input wire logic IN_VALID,
  output logic IN_READY,
  output logic [WIDTH-1:0] OUT_DATA,
  output logic OUT_VALID,
  input wire logic OUT_READY
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;

  assign IN_READY = (count != (AW+1)'(DEPTH));
  assign OUT_VALID = (count != '0);
  assign OUT_DATA = mem[rd_ptr];
  assign push = IN_VALID && IN_READY;
  assign pop = OUT_VALID && OUT_READY;

  always_ff @(posedge CLK) begin
    if (push) begin
      mem[wr_ptr] <= IN_DATA;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST || FLUSH) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

module lcdsd_decoder
  import lcdsd_pkg::*;
(
  input wire logic CLK,
  input wire logic RST,
  input wire logic SERIAL_CLK,
  input wire logic SERIAL_IN_LINE,
  input wire logic CHIP_SEL_N,
  input wire logic CMD_DATA_SELECT,
  input wire logic PANEL_INIT_N,
  input wire logic DECODE_HOLD,
  input wire logic [3:0] SCAN_PAGE,
  input wire logic [7:0] SCAN_COLUMN,
  output logic [7:0] SCAN_DATA,
  output logic RX_READY,
  output logic [7:0] STATUS_BYTE,
  output logic DISPLAY_ON,
  output logic [5:0] START_LINE,
  output logic [3:0] PAGE_ADDR,
  output logic [7:0] COLUMN_ADDR,
  output logic COLUMN_MIRROR,
  output logic PIXEL_INVERT,
  output logic ALL_PIXELS_ON,
  output logic BIAS_SELECT,
  output logic RMW_MODE,
  output logic ROW_SCAN_REVERSE,
  output logic [2:0] POWER_MODE,
  output logic [2:0] REGULATOR_DIVIDER_RATIO,
  output logic [5:0] DRIVE_VOLUME,
  output logic INDICATOR_ON,
  output logic [1:0] INDICATOR_FLASH,
  output logic PARTIAL_MODE,
  output logic [2:0] PARTIAL_DUTY,
  output logic [2:0] PARTIAL_BIAS,
  output logic [5:0] PARTIAL_START,
  output logic NLINE_ON,
  output logic [4:0] NLINE_COUNT,
  output logic OSC_SELECT,
  output logic [3:0] DCDC_DIVISION
);

  function automatic logic in_range(input logic [7:0] b, input logic [7:0] lo, input logic [7:0] hi);
    in_range = (b >= lo) && (b <= hi);
  endfunction

  // Two-stage synchronisers for the five serial-link and init pins
  logic [4:0] pin_meta;
  logic [4:0] pin_sync;
  logic sclk_prev;
  always_ff @(posedge CLK) begin
    if (RST) begin
      pin_meta <= 5'h1F;
      pin_sync <= 5'h1F;
      // Serial clock idles high; a low here would fake an edge
      sclk_prev <= 1'b1;
    end else begin
      pin_meta <= {PANEL_INIT_N, CMD_DATA_SELECT, CHIP_SEL_N, SERIAL_IN_LINE, SERIAL_CLK};
      pin_sync <= pin_meta;
      sclk_prev <= pin_sync[0];
    end
  end

  logic s_sclk;
  logic s_sdata;
  logic s_cs_n;
  logic s_cds;
  logic s_init_n;
  logic init_active;
  assign s_sclk = pin_sync[0];
  assign s_sdata = pin_sync[1];
  assign s_cs_n = pin_sync[2];
  assign s_cds = pin_sync[3];
  assign s_init_n = pin_sync[4];
  assign init_active = !s_init_n;

  // Serial shifter
  logic [2:0] bit_cnt;
  logic [6:0] shift;
  logic byte_done;
  logic [7:0] rx_byte;
  logic rx_cds;
  logic sclk_rise;
  logic fifo_in_ready;
  assign sclk_rise = s_sclk && !sclk_prev && !s_cs_n; // [R3] [R25]

  always_ff @(posedge CLK) begin
    if (RST || init_active || s_cs_n) begin // [R3]
      bit_cnt <= 3'h0;
      shift <= 7'h00;
    end else if (sclk_rise) begin
      shift <= {shift[5:0], s_sdata}; // [R25]
      bit_cnt <= bit_cnt + 3'h1;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST || init_active) begin
      byte_done <= 1'b0;
      rx_byte <= 8'h00;
      rx_cds <= 1'b0;
    end else begin
      byte_done <= sclk_rise && (bit_cnt == LCDSD_BIT_LAST);
      if (sclk_rise && (bit_cnt == LCDSD_BIT_LAST)) begin
        rx_byte <= {shift, s_sdata}; // [R25]
        rx_cds <= s_cds; // [R1]
      end
    end
  end

  // Bytes wait here while the decoder is held off the RAM
  logic [8:0] fifo_out;
  logic fifo_valid;
  logic fifo_pop;
  assign fifo_pop = !DECODE_HOLD && !init_active;
  assign RX_READY = fifo_in_ready;

  lcdsd_fifo #(
    .WIDTH(LCDSD_FIFO_WIDTH),
    .DEPTH(LCDSD_FIFO_DEPTH)
  ) u_fifo (
    .CLK(CLK),
    .RST(RST),
    .FLUSH(init_active),
    .IN_DATA({rx_cds, rx_byte}),
    .IN_VALID(byte_done),
    .IN_READY(fifo_in_ready),
    .OUT_DATA(fifo_out),
    .OUT_VALID(fifo_valid),
    .OUT_READY(fifo_pop)
  );

  logic take;
  logic is_data;
  logic is_cmd;
  logic [7:0] b;
  assign take = fifo_valid && fifo_pop;
  assign b = fifo_out[7:0];
  assign is_data = take && fifo_out[8]; // [R1]
  assign is_cmd = take && !fifo_out[8]; // [R1]

  lcdsd_expect_t expect_st;
  logic soft_reset;
  logic hard_reset;
  logic reg_reset;
  logic arg_byte;
  assign arg_byte = is_cmd && (expect_st != LCDSD_EXP_CMD);
  assign soft_reset = is_cmd && !arg_byte && (b == OP_SOFT_RESET);
  assign hard_reset = RST || init_active; // [R2]
  assign reg_reset = hard_reset || soft_reset; // [R23]

  // Second byte of two-byte commands
  always_ff @(posedge CLK) begin
    if (reg_reset) begin
      expect_st <= LCDSD_EXP_CMD;
    end else if (is_cmd) begin
      if (arg_byte) begin
        expect_st <= LCDSD_EXP_CMD;
      end else begin
        case (b)
          OP_VOLUME: expect_st <= LCDSD_EXP_VOLUME; // [R19]
          OP_IND_LO, OP_IND_HI: expect_st <= LCDSD_EXP_INDICATOR; // [R20]
          OP_PSTART: expect_st <= LCDSD_EXP_PSTART; // [R21]
          OP_NLINE_ON: expect_st <= LCDSD_EXP_NLINE; // [R22]
          OP_DCDC: expect_st <= LCDSD_EXP_DCDC;
          default: expect_st <= LCDSD_EXP_CMD;
        endcase
      end
    end
  end

  // Settings kept by soft reset
  always_ff @(posedge CLK) begin
    if (hard_reset) begin
      DISPLAY_ON <= 1'b0;
      COLUMN_MIRROR <= 1'b0;
      PIXEL_INVERT <= 1'b0;
      ALL_PIXELS_ON <= 1'b0;
      BIAS_SELECT <= 1'b0;
      POWER_MODE <= RST_POWER;
      PARTIAL_MODE <= 1'b0;
      PARTIAL_DUTY <= 3'h0;
      PARTIAL_BIAS <= 3'h0;
      PARTIAL_START <= RST_START_LINE;
      NLINE_ON <= 1'b0;
      NLINE_COUNT <= RST_NLINE;
      OSC_SELECT <= 1'b0;
      DCDC_DIVISION <= RST_DCDC;
    end else if (is_cmd && arg_byte) begin
      case (expect_st)
        LCDSD_EXP_PSTART: PARTIAL_START <= b[5:0]; // [R21]
        LCDSD_EXP_NLINE: begin
          NLINE_ON <= 1'b1; // [R22]
          NLINE_COUNT <= b[4:0];
        end
        LCDSD_EXP_DCDC: DCDC_DIVISION <= b[3:0];
        default: ;
      endcase
    end else if (is_cmd) begin
      if (b == OP_DISP_OFF || b == OP_DISP_ON) DISPLAY_ON <= b[0]; // [R4]
      if (b == OP_ADC_NORM || b == OP_ADC_REV) COLUMN_MIRROR <= b[0]; // [R11]
      if (b == OP_INV_LO || b == OP_INV_HI) PIXEL_INVERT <= b[0]; // [R12]
      if (b == OP_ALLON_LO || b == OP_ALLON_HI) ALL_PIXELS_ON <= b[0]; // [R13]
      if (b == OP_BIAS_LO || b == OP_BIAS_HI) BIAS_SELECT <= b[0]; // [R14]
      if (in_range(b, OP_POWER_LO, OP_POWER_HI)) POWER_MODE <= b[2:0]; // [R17]
      if (b == OP_PART_LO || b == OP_PART_HI) PARTIAL_MODE <= b[0]; // [R21]
      if (in_range(b, OP_PDUTY_LO, OP_PDUTY_HI)) PARTIAL_DUTY <= b[2:0]; // [R21]
      if (in_range(b, OP_PBIAS_LO, OP_PBIAS_HI)) PARTIAL_BIAS <= b[2:0]; // [R21]
      if (b == OP_NLINE_OFF) NLINE_ON <= 1'b0; // [R22]
      if (b == OP_OSC_LO || b == OP_OSC_HI) OSC_SELECT <= b[0]; // [R27]
    end
  end

  // Pointers and mode registers, cleared by soft reset as well
  logic [7:0] rmw_saved;
  always_ff @(posedge CLK) begin
    if (reg_reset) begin // [R23]
      START_LINE <= RST_START_LINE;
      PAGE_ADDR <= RST_PAGE;
      COLUMN_ADDR <= RST_COLUMN;
      ROW_SCAN_REVERSE <= 1'b0;
      REGULATOR_DIVIDER_RATIO <= RST_RATIO;
      DRIVE_VOLUME <= RST_VOLUME;
      INDICATOR_ON <= 1'b0;
      INDICATOR_FLASH <= 2'h0;
      RMW_MODE <= 1'b0;
      rmw_saved <= RST_COLUMN;
    end else if (is_data) begin
      // Column saturates at the last address if set at or below it; a column set above it counts on and wraps
      if (COLUMN_ADDR != LCDSD_COL_LAST) COLUMN_ADDR <= COLUMN_ADDR + 8'h01; // [R15]
    end else if (arg_byte) begin
      case (expect_st)
        LCDSD_EXP_VOLUME: DRIVE_VOLUME <= b[5:0]; // [R19]
        LCDSD_EXP_INDICATOR: INDICATOR_FLASH <= b[1:0]; // [R20]
        default: ;
      endcase
    end else if (is_cmd) begin
      if (in_range(b, OP_START_LO, OP_START_HI)) START_LINE <= b[5:0]; // [R5]
      if (in_range(b, OP_PAGE_LO, OP_PAGE_HI)) PAGE_ADDR <= b[3:0]; // [R6]
      if (in_range(b, OP_COLH_LO, OP_COLH_HI)) COLUMN_ADDR[7:4] <= b[3:0]; // [R7]
      if (in_range(b, OP_COLL_LO, OP_COLL_HI)) COLUMN_ADDR[3:0] <= b[3:0]; // [R7]
      if (in_range(b, OP_COMDIR_LO, OP_COMDIR_HI)) ROW_SCAN_REVERSE <= b[3]; // [R16]
      if (in_range(b, OP_RATIO_LO, OP_RATIO_HI)) REGULATOR_DIVIDER_RATIO <= b[2:0]; // [R18]
      if (b == OP_IND_LO || b == OP_IND_HI) INDICATOR_ON <= b[0]; // [R20]
      if (b == OP_RMW) begin
        RMW_MODE <= 1'b1; // [R15]
        rmw_saved <= COLUMN_ADDR;
      end
      if (b == OP_RMW_END) begin
        RMW_MODE <= 1'b0; // [R15]
        if (RMW_MODE) COLUMN_ADDR <= rmw_saved;
      end
      // Test codes, NOP and unlisted codes fall through untouched [R26]
    end
  end

  // Display RAM: soft reset and init pin leave it alone
  logic [7:0] dram [LCDSD_PAGES * LCDSD_COLS];
  logic wr_ok;
  logic rd_ok;
  assign wr_ok = (PAGE_ADDR < 4'(LCDSD_PAGES)) && (COLUMN_ADDR < 8'(LCDSD_COLS));
  assign rd_ok = (SCAN_PAGE < 4'(LCDSD_PAGES)) && (SCAN_COLUMN < 8'(LCDSD_COLS));

  function automatic logic [10:0] ram_index(input logic [3:0] pg, input logic [7:0] col);
    ram_index = 11'(pg) * 11'(LCDSD_COLS) + 11'(col);
  endfunction

  always_ff @(posedge CLK) begin
    if (is_data && wr_ok && !hard_reset) begin
      dram[ram_index(PAGE_ADDR, COLUMN_ADDR)] <= b; // [R9]
    end
  end

  // Only the panel scan reads RAM; the serial link has no read path
  always_ff @(posedge CLK) begin
    if (RST) begin
      SCAN_DATA <= 8'h00;
    end else if (rd_ok) begin
      SCAN_DATA <= dram[ram_index(SCAN_PAGE, SCAN_COLUMN)]; // [R10] [R24]
    end else begin
      SCAN_DATA <= 8'h00;
    end
  end

  // Status: busy, normal order, off, reset in upper nibble
  always_ff @(posedge CLK) begin
    if (RST) begin
      STATUS_BYTE <= 8'h00;
    end else begin
      STATUS_BYTE <= {fifo_valid || init_active || soft_reset, !COLUMN_MIRROR, !DISPLAY_ON,
                      init_active || soft_reset, 4'h0}; // [R8]
    end
  end
endmodule

`default_nettype wire

// ===== verif/lcdsd_props.sv
// Port-level assertions for the LCD serial command decoder
`timescale 1ns/1ps
`default_nettype none
module lcdsd_props (
  input wire logic CLK,
  input wire logic RST,
  input wire logic CHIP_SEL_N,
  input wire logic PANEL_INIT_N,
  input wire logic [3:0] SCAN_PAGE,
  input wire logic [7:0] SCAN_DATA,
  input wire logic RX_READY,
  input wire logic [7:0] STATUS_BYTE,
  input wire logic DISPLAY_ON,
  input wire logic [5:0] START_LINE,
  input wire logic [3:0] PAGE_ADDR,
  input wire logic [7:0] COLUMN_ADDR,
  input wire logic COLUMN_MIRROR,
  input wire logic [5:0] DRIVE_VOLUME
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);

  a_status_nibble: assert property (STATUS_BYTE[3:0] == 4'h0)
    else $error("status low nibble not zero");
  a_reset_values: assert property ($past(RST) |-> !DISPLAY_ON
    && DRIVE_VOLUME == 6'h20 && COLUMN_ADDR == 8'h00 && RX_READY)
    else $error("settings wrong after reset");
  a_init_clears: assert property ((!PANEL_INIT_N) [*4] |=> !DISPLAY_ON
    && DRIVE_VOLUME == 6'h20 && PAGE_ADDR == 4'h0 && RX_READY)
    else $error("init pin did not clear settings");
  // Busy must be low a few cycles so no queued byte is still being decoded
  a_idle_settings: assert property ((CHIP_SEL_N && PANEL_INIT_N) [*8]
    ##0 (PANEL_INIT_N && !STATUS_BYTE[7]) [*3]
    |=> $stable(DISPLAY_ON) && $stable(PAGE_ADDR) && $stable(START_LINE))
    else $error("settings changed with chip deselected");
  a_on_flag: assert property ($changed(DISPLAY_ON) |-> ##[1:2] STATUS_BYTE[5] == !DISPLAY_ON)
    else $error("status on/off flag wrong");
  a_order_flag: assert property ($changed(COLUMN_MIRROR) |-> ##[1:2] STATUS_BYTE[6] == !COLUMN_MIRROR)
    else $error("status order flag wrong");
  a_page_range: assert property (PAGE_ADDR <= 4'h8)
    else $error("page beyond last page");
  a_col_range: assert property (COLUMN_ADDR <= 8'h83)
    else $error("column beyond last column");
  a_scan_blank: assert property (SCAN_PAGE > 4'h8 |=> SCAN_DATA == 8'h00)
    else $error("scan outside RAM not zero");

  c_turn_on: cover property ($rose(DISPLAY_ON));
  c_fifo_full: cover property ($fell(RX_READY));
  c_init_pin: cover property ($fell(PANEL_INIT_N));
endmodule
`default_nettype wire

// ===== verif/lcdsd_host.sv
// Host model driving the write-only serial link
`timescale 1ns/1ps
`default_nettype none
module lcdsd_host (
  input wire logic clk,
  output logic sclk,
  output logic sdi,
  output logic cs_n,
  output logic sel
);
  // Serial clock idles high and stands still between bytes
  initial begin
    sclk = 1'b1;
    sdi = 1'b0;
    cs_n = 1'b1;
    sel = 1'b0;
  end

  task automatic send(input logic [7:0] b, input logic dsel, input logic csn);
    sel <= dsel;
    cs_n <= csn;
    repeat (2) @(posedge clk);
    for (int i = 7; i >= 0; i--) begin
      sdi <= b[i];
      sclk <= 1'b0;
      repeat (4) @(posedge clk);
      sclk <= 1'b1;
      repeat (4) @(posedge clk);
    end
    cs_n <= 1'b1;
    // Released lines show the inverse, not a stale value
    sel <= ~dsel;
    sdi <= ~b[0];
    repeat (2) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// ===== verif/lcdsd_tb.sv
// Self-checking bench for the LCD serial command decoder
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic CLK = 1'b0;
  logic RST = 1'b1;
  logic PANEL_INIT_N = 1'b1;
  logic DECODE_HOLD = 1'b0;
  logic [3:0] SCAN_PAGE = 4'h0;
  logic [7:0] SCAN_COLUMN = 8'h00;
  logic SERIAL_CLK, SERIAL_IN_LINE, CHIP_SEL_N, CMD_DATA_SELECT;
  logic [7:0] SCAN_DATA, STATUS_BYTE, COLUMN_ADDR;
  logic [5:0] START_LINE, DRIVE_VOLUME, PARTIAL_START;
  logic [3:0] PAGE_ADDR, DCDC_DIVISION;
  logic [2:0] POWER_MODE, REGULATOR_DIVIDER_RATIO, PARTIAL_DUTY, PARTIAL_BIAS;
  logic [4:0] NLINE_COUNT;
  logic [1:0] INDICATOR_FLASH;
  logic RX_READY, DISPLAY_ON, COLUMN_MIRROR, PIXEL_INVERT, ALL_PIXELS_ON, BIAS_SELECT;
  logic RMW_MODE, ROW_SCAN_REVERSE, INDICATOR_ON, PARTIAL_MODE, NLINE_ON, OSC_SELECT;
  int error_cnt = 0;
  int total_checks = 0;

  initial begin
    forever #10 CLK = ~CLK;
  end

  lcdsd_host host (.clk(CLK), .sclk(SERIAL_CLK), .sdi(SERIAL_IN_LINE), .cs_n(CHIP_SEL_N),
    .sel(CMD_DATA_SELECT));
  lcdsd_decoder dut (.CLK, .RST, .SERIAL_CLK, .SERIAL_IN_LINE, .CHIP_SEL_N, .CMD_DATA_SELECT,
    .PANEL_INIT_N, .DECODE_HOLD, .SCAN_PAGE, .SCAN_COLUMN, .SCAN_DATA, .RX_READY, .STATUS_BYTE,
    .DISPLAY_ON, .START_LINE, .PAGE_ADDR, .COLUMN_ADDR, .COLUMN_MIRROR, .PIXEL_INVERT,
    .ALL_PIXELS_ON, .BIAS_SELECT, .RMW_MODE, .ROW_SCAN_REVERSE, .POWER_MODE,
    .REGULATOR_DIVIDER_RATIO, .DRIVE_VOLUME, .INDICATOR_ON, .INDICATOR_FLASH, .PARTIAL_MODE,
    .PARTIAL_DUTY, .PARTIAL_BIAS, .PARTIAL_START, .NLINE_ON, .NLINE_COUNT, .OSC_SELECT,
    .DCDC_DIVISION);

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s: expected %h, seen %h", n, e, g);
    end
  endtask

  // Gap after each byte covers the pipeline to the setting registers
  task automatic cmd(input logic [7:0] b);
    host.send(b, 1'b0, 1'b0);
    repeat (6) @(posedge CLK);
  endtask

  task automatic dat(input logic [7:0] b);
    host.send(b, 1'b1, 1'b0);
    repeat (6) @(posedge CLK);
  endtask

  task automatic scan(input logic [3:0] p, input logic [7:0] c);
    SCAN_PAGE <= p;
    SCAN_COLUMN <= c;
    repeat (2) @(posedge CLK);
  endtask

  task automatic conclude;
    $display("checks %0d, errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge CLK);
    error_cnt++;
    conclude();
  end

  initial begin
    repeat (16) @(posedge CLK);
    RST <= 1'b0;
    repeat (3) @(posedge CLK);
    chk("volume", 8'h20, DRIVE_VOLUME);
    chk("status", 8'h60, STATUS_BYTE);
    cmd(8'hAF);
    chk("on", 8'h01, DISPLAY_ON);
    cmd(8'hAE);
    chk("off", 8'h00, DISPLAY_ON);
    cmd(8'hAF);
    cmd(8'h7F);
    chk("start", 8'h3F, START_LINE);
    cmd(8'hB8);
    chk("page", 8'h08, PAGE_ADDR);
    cmd(8'h18);
    cmd(8'h03);
    chk("column", 8'h83, COLUMN_ADDR);
    cmd(8'hA1);
    cmd(8'hA7);
    cmd(8'hA5);
    cmd(8'hA3);
    cmd(8'hCF);
    cmd(8'h2D);
    cmd(8'h23);
    cmd(8'hE5);
    chk("mirror", 8'h01, COLUMN_MIRROR);
    chk("status", 8'h00, STATUS_BYTE);
    chk("invert", 8'h01, PIXEL_INVERT);
    chk("all on", 8'h01, ALL_PIXELS_ON);
    chk("bias", 8'h01, BIAS_SELECT);
    chk("row dir", 8'h01, ROW_SCAN_REVERSE);
    chk("power", 8'h05, POWER_MODE);
    chk("ratio", 8'h03, REGULATOR_DIVIDER_RATIO);
    chk("osc", 8'h01, OSC_SELECT);
    cmd(8'h81);
    cmd(8'h15);
    chk("volume", 8'h15, DRIVE_VOLUME);
    cmd(8'hAD);
    cmd(8'h02);
    chk("indicator", 8'h01, INDICATOR_ON);
    chk("flash", 8'h02, INDICATOR_FLASH);
    cmd(8'h83);
    cmd(8'h35);
    cmd(8'h3C);
    cmd(8'hD3);
    cmd(8'h2A);
    chk("partial", 8'h01, PARTIAL_MODE);
    chk("p duty", 8'h05, PARTIAL_DUTY);
    chk("p bias", 8'h04, PARTIAL_BIAS);
    chk("p start", 8'h2A, PARTIAL_START);
    cmd(8'h85);
    cmd(8'h13);
    chk("nline", 8'h01, NLINE_ON);
    chk("count", 8'h13, NLINE_COUNT);
    cmd(8'h84);
    chk("nline off", 8'h00, NLINE_ON);
    cmd(8'hF5);
    cmd(8'hE3);
    chk("volume", 8'h15, DRIVE_VOLUME);
    chk("start", 8'h3F, START_LINE);
    host.send(8'hAE, 1'b0, 1'b1);
    repeat (6) @(posedge CLK);
    chk("on", 8'h01, DISPLAY_ON);
    cmd(8'hB1);
    cmd(8'h10);
    cmd(8'h05);
    dat(8'h5A);
    chk("column", 8'h06, COLUMN_ADDR);
    scan(4'h1, 8'h05);
    chk("ram", 8'h5A, SCAN_DATA);
    scan(4'h9, 8'h00);
    chk("blank", 8'h00, SCAN_DATA);
    cmd(8'hE0);
    chk("rmw", 8'h01, RMW_MODE);
    dat(8'h11);
    dat(8'h22);
    chk("column", 8'h08, COLUMN_ADDR);
    cmd(8'hEE);
    chk("column", 8'h06, COLUMN_ADDR);
    chk("rmw", 8'h00, RMW_MODE);
    scan(4'h1, 8'h07);
    chk("ram", 8'h22, SCAN_DATA);
    // DC/DC division is outside the soft-reset set, so it must survive
    cmd(8'hE6);
    cmd(8'hC5);
    cmd(8'hE2);
    chk("start", 8'h00, START_LINE);
    chk("volume", 8'h20, DRIVE_VOLUME);
    chk("page", 8'h00, PAGE_ADDR);
    chk("on", 8'h01, DISPLAY_ON);
    chk("power", 8'h05, POWER_MODE);
    chk("dcdc", 8'h05, DCDC_DIVISION);
    scan(4'h1, 8'h05);
    chk("ram", 8'h5A, SCAN_DATA);
    PANEL_INIT_N <= 1'b0;
    repeat (8) @(posedge CLK);
    PANEL_INIT_N <= 1'b1;
    repeat (4) @(posedge CLK);
    chk("on", 8'h00, DISPLAY_ON);
    chk("power", 8'h00, POWER_MODE);
    chk("mirror", 8'h00, COLUMN_MIRROR);
    chk("dcdc", 8'h00, DCDC_DIVISION);
    chk("ram", 8'h5A, SCAN_DATA);
    // Two bytes past capacity must be dropped, not overwrite queued ones
    DECODE_HOLD <= 1'b1;
    repeat (34) dat(8'hC3);
    chk("ready", 8'h00, RX_READY);
    chk("busy", 8'h01, STATUS_BYTE[7]);
    DECODE_HOLD <= 1'b0;
    repeat (100) @(posedge CLK);
    chk("column", 8'h20, COLUMN_ADDR);
    chk("ready", 8'h01, RX_READY);
    chk("status", 8'h60, STATUS_BYTE);
    scan(4'h0, 8'h1F);
    chk("ram", 8'hC3, SCAN_DATA);
    conclude();
  end
endmodule

bind lcdsd_decoder lcdsd_props props (.CLK, .RST, .CHIP_SEL_N, .PANEL_INIT_N, .SCAN_PAGE,
  .SCAN_DATA, .RX_READY, .STATUS_BYTE, .DISPLAY_ON, .START_LINE, .PAGE_ADDR, .COLUMN_ADDR,
  .COLUMN_MIRROR, .DRIVE_VOLUME);
`default_nettype wire
